// File: hw/latrap.sv
// Legacy audio I/O trap unit with APB register access.
// Assumes io cycles come from logic on mclk, one cycle per valid pulse.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "latrap_map.svh"

// Functional notes
// - DMA trap hit sets read-to-clear status
// - MIDI_PORT_UNIT traps set status, gated by bits six, five
// - Sound/synth trap: bit10, or bit13 when fast write
// - Sound card trap needs enable bit two
// - Capture ten-bit address of trapped access
// - Enable register resets zero; reserved written zero
// - Fast write answers listed ports; even ports set no trap status, only the fast write event
// - Fast read field returned on emulated reads
// - High DMA enable traps C0h-DFh into bit12
// - Low DMA enable traps 00h-0Fh
// - High MIDI_PORT_UNIT enable traps 330h-331h
// - All trap status rolls up to interrupt output
// - Even fast write sets no trap status; odd sets bit13
// - Low MIDI_PORT_UNIT enable traps 300h-301h
// - Synth enable traps 388h-38Bh
// - Two-bit select picks sound card window
module latrap
  import latrap_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire latrap_io_t  io_cyc,
  output latrap_rsp_t      io_rsp,
  output logic             system_mgmt_interrupt,
  output logic             trap_pulse,
  output logic             irq
);

  // Inclusive port range test
  function automatic logic in_rng(input logic [9:0] a, input logic [9:0] lo,
                                  input logic [9:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction : in_rng

  // Sound card window base from the two-bit select
  function automatic logic [9:0] snd_base(input logic [1:0] sel);
    snd_base = 10'h220 + {4'h0, sel, 4'h0} + {4'h0, sel, 4'h0};
  endfunction : snd_base

  logic [15:0]          enable_reg, enable_next;
  logic [31:0]          status_reg, status_next;
  logic [31:0]          prdata_reg, prdata_next;
  logic                 trap_reg, trap_next;
  logic [`LAT_IRQ_W-1:0] ist_reg, ist_next;
  logic [`LAT_IRQ_W-1:0] ien_reg, ien_next;

  logic       setup, access, wr_acc, rd_acc, mapped;
  logic [9:0] a;
  logic [9:0] sb;
  logic       hit_dma, hit_mpu, hit_snd, hit_syn;
  logic       fwr_port, frd_port, fast_wr, fast_rd, odd, trap_ev;

  // APB phases; the slave never waits
  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign wr_acc = access && pwrite;
  assign rd_acc = access && !pwrite;
  assign mapped = (paddr == `LAT_OFS_STATUS) || (paddr == `LAT_OFS_ENABLE) ||
                  (paddr == `LAT_OFS_IRQ_ST) || (paddr == `LAT_OFS_IRQ_CLR) ||
                  (paddr == `LAT_OFS_IRQ_EN);
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata  = prdata_reg;

  // Address decode of the current I/O cycle, all in one cycle
  assign a  = io_cyc.addr;
  assign sb = snd_base(enable_reg[1:0]);
  always_comb
  begin
    hit_dma = (enable_reg[`LAT_B_HIDMA] && in_rng(a, 10'h0c0, 10'h0df)) ||
              (enable_reg[`LAT_B_LODMA] && in_rng(a, 10'h000, 10'h00f));
    hit_mpu = (enable_reg[`LAT_B_HIMPU] && in_rng(a, 10'h330, 10'h331)) ||
              (enable_reg[`LAT_B_LOMPU] && in_rng(a, 10'h300, 10'h301));
    hit_snd = enable_reg[`LAT_B_SNDCARD] && in_rng(a, sb, sb + 10'h00f);
    hit_syn = enable_reg[`LAT_B_SYNTH] && in_rng(a, 10'h388, 10'h38b);
    fwr_port = (a == 10'h388) || (a == 10'h38a) || (a == 10'h38b) ||
               (a == sb) || (a == sb + 10'h002) || (a == sb + 10'h008);
    frd_port = in_rng(a, 10'h388, 10'h38b) || in_rng(a, sb, sb + 10'h003) ||
               (a == sb + 10'h008) || (a == sb + 10'h009);
  end

  // Fast paths take over the cycle; an even fast write raises no trap or trap status
  assign fast_wr = io_cyc.valid && io_cyc.write && enable_reg[`LAT_B_FASTWR] &&
                   fwr_port;
  assign fast_rd = io_cyc.valid && !io_cyc.write && enable_reg[`LAT_B_FASTRD] &&
                   frd_port;
  assign odd     = a[0];
  assign trap_ev = io_cyc.valid && !fast_rd && !(fast_wr && !odd) &&
                   (hit_dma || hit_mpu || hit_snd || hit_syn || fast_wr);

  // The unit answers fast cycles itself; reads carry the fast read bits
  assign io_rsp.claim = fast_wr || fast_rd;
  assign io_rsp.rdata = fast_rd ? {6'h00, enable_reg[10:9]} : 8'h00;

  // Register next state: events set, software reads and writes clear
  always_comb
  begin
    enable_next = enable_reg;
    status_next = status_reg;
    ist_next    = ist_reg;
    ien_next    = ien_reg;
    prdata_next = prdata_reg;
    trap_next   = trap_ev;
    // Read data is latched in the setup phase so prdata comes from a flop
    if (setup && !pwrite)
    begin
      case (paddr)
        `LAT_OFS_STATUS: prdata_next = status_reg;
        `LAT_OFS_ENABLE: prdata_next = {16'h0000, enable_reg};
        `LAT_OFS_IRQ_ST: prdata_next = {{(32-`LAT_IRQ_W){1'b0}}, ist_reg};
        `LAT_OFS_IRQ_EN: prdata_next = {{(32-`LAT_IRQ_W){1'b0}}, ien_reg};
        default:         prdata_next = 32'h0000_0000;
      endcase
    end
    // Read-to-clear drops only the bits that were actually reported
    if (rd_acc && paddr == `LAT_OFS_STATUS)
      status_next[13:10] = status_reg[13:10] & ~prdata_reg[13:10];
    if (wr_acc && paddr == `LAT_OFS_ENABLE)
      enable_next = pwdata[15:0] & `LAT_ENABLE_MASK;
    if (wr_acc && paddr == `LAT_OFS_IRQ_EN)
      ien_next = pwdata[`LAT_IRQ_W-1:0];
    if (wr_acc && paddr == `LAT_OFS_IRQ_CLR)
      ist_next = ist_reg & ~pwdata[`LAT_IRQ_W-1:0];
    // Capture of the trapped cycle; a set after the clear above wins
    if (trap_ev)
    begin
      status_next[9:0] = a;
      status_next[14]  = io_cyc.write;
      if (hit_dma)
        status_next[`LAT_B_ST_DMA] = 1'b1;
      if (hit_mpu)
        status_next[`LAT_B_ST_MPU] = 1'b1;
      if (fast_wr)
        status_next[`LAT_B_ST_FAST] = 1'b1;
      else if (hit_snd || hit_syn)
      begin
        if (enable_reg[`LAT_B_FASTWR])
          status_next[`LAT_B_ST_FAST] = 1'b1;
        else
          status_next[`LAT_B_ST_SND] = 1'b1;
      end
      if (io_cyc.write && !fast_wr)
        status_next[23:16] = io_cyc.data;
    end
    // Fast write data and A1 are kept whether or not it interrupts
    if (fast_wr)
    begin
      status_next[15] = a[1];
      if (odd)
        status_next[23:16] = io_cyc.data;
      else
        status_next[31:24] = io_cyc.data;
    end
    // Sticky interrupt events: trap, fast write, fast read
    ist_next = ist_next | {fast_rd, fast_wr, trap_ev};
  end

  // Registers only
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      enable_reg <= `LAT_ENABLE_RST;
      status_reg <= 32'h0000_0000;
      prdata_reg <= 32'h0000_0000;
      trap_reg   <= 1'b0;
      ist_reg    <= '0;
      ien_reg    <= '0;
    end
    else
    begin
      enable_reg <= enable_next;
      status_reg <= status_next;
      prdata_reg <= prdata_next;
      trap_reg   <= trap_next;
      ist_reg    <= ist_next;
      ien_reg    <= ien_next;
    end
  end

  // Any third-level trap status rolls up into the interrupt level
  assign system_mgmt_interrupt = |status_reg[13:10];
  assign trap_pulse            = trap_reg;
  assign irq                   = |(ist_reg & ien_reg);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // Status read that completes with no new trap in its setup or access cycle
  sequence rd_status_s;
    setup && !pwrite && paddr == `LAT_OFS_STATUS && !trap_ev ##1
    rd_acc && paddr == `LAT_OFS_STATUS && !trap_ev;
  endsequence

  // Trap of a DMA range sets its flag and pulses once
  dma_sets_a: assert property (trap_ev && hit_dma |=> status_reg[12] && trap_pulse)
    else $error("DMA trap did not set status");

  // A trap in either phase of the read keeps its bit, so both phases must be quiet
  status_rc_a: assert property (rd_status_s |=> status_reg[13:10] == 4'h0)
    else $error("Status not cleared by read");

  mpu_roll_a: assert property (trap_ev && hit_mpu
                               |=> status_reg[11] && system_mgmt_interrupt)
    else $error("MIDI_PORT_UNIT trap not reported");

  snd_route_a: assert property (trap_ev && !fast_wr && hit_snd && !enable_reg[11]
                                |=> status_reg[10])
    else $error("Sound trap not in low bit");

  snd_fast_a: assert property (trap_ev && !fast_wr && hit_snd && enable_reg[11]
                               |=> status_reg[13] && !$past(status_reg[10]) -> !status_reg[10])
    else $error("Sound trap not routed to bit13");

  addr_cap_a: assert property (trap_ev |=> status_reg[9:0] == $past(io_cyc.addr))
    else $error("Trap address not captured");

  en_write_a: assert property (wr_acc && paddr == `LAT_OFS_ENABLE
                               |=> enable_reg == ($past(pwdata[15:0]) & 16'h0fff))
    else $error("Enable write lost");

  even_quiet_a: assert property (fast_wr && !odd |=> !trap_pulse ##1 $stable(status_reg[13:10])
                                 or trap_pulse)
    else $error("Even fast write interrupted");

  fast_claim_a: assert property (fast_wr |-> io_rsp.claim)
    else $error("Fast write not claimed");

  high_dma_a: assert property (io_cyc.valid && enable_reg[8] && !fast_rd && !fast_wr &&
                               in_rng(io_cyc.addr, 10'h0c0, 10'h0df) |=> status_reg[12])
    else $error("High DMA range missed");

  // Low DMA range reports through the shared DMA flag
  low_dma_a: assert property (io_cyc.valid && enable_reg[7] && !fast_rd && !fast_wr &&
                              in_rng(io_cyc.addr, 10'h000, 10'h00f) |=> status_reg[12])
    else $error("Low DMA range missed");

  // High MIDI port pair
  high_mpu_a: assert property (io_cyc.valid && enable_reg[6] && !fast_rd && !fast_wr &&
                               in_rng(io_cyc.addr, 10'h330, 10'h331) |=> status_reg[11])
    else $error("High MIDI range missed");

  // Low MIDI port pair
  low_mpu_a: assert property (io_cyc.valid && enable_reg[5] && !fast_rd && !fast_wr &&
                              in_rng(io_cyc.addr, 10'h300, 10'h301) |=> status_reg[11])
    else $error("Low MIDI range missed");

  // Synth ports land in the low sound bit while fast write is off
  synth_trap_a: assert property (io_cyc.valid && enable_reg[3] && !enable_reg[11] &&
                                 !fast_rd &&
                                 in_rng(io_cyc.addr, 10'h388, 10'h38b) |=> status_reg[10])
    else $error("Synth range missed");

  // With sound and synth off and no other hit, nothing traps
  snd_gate_a: assert property (!enable_reg[2] && !enable_reg[3] && !hit_dma && !hit_mpu &&
                               !fast_wr |-> !trap_ev)
    else $error("Sound trap while disabled");

  // Window base steps by 20h with the select
  snd_window_a: assert property (sb == 10'h220 + {enable_reg[1:0], 5'h00})
    else $error("Sound window base wrong");

  // Fast read answers with the two-bit field and never traps
  fast_rd_a: assert property (fast_rd |-> io_rsp.claim && !trap_ev &&
                              io_rsp.rdata == {6'h00, enable_reg[10:9]})
    else $error("Fast read answer wrong");

  // Even fast write is answered without a trap
  even_notrap_a: assert property (fast_wr && !odd |-> io_rsp.claim && !trap_ev)
    else $error("Even fast write trapped");

  // Odd fast write traps into bit 13
  odd_fast_a: assert property (fast_wr && odd |=> status_reg[13] && trap_pulse)
    else $error("Odd fast write not reported");

  // Every trap shows at the interrupt level next cycle
  smi_level_a: assert property (trap_ev |=> system_mgmt_interrupt)
    else $error("Trap not rolled up");

  // No pulse without a trap in the cycle before
  pulse_cause_a: assert property (!trap_ev |=> !trap_pulse)
    else $error("Spurious trap pulse");

  // Reserved enable bits never hold a one
  en_rsvd_a: assert property (enable_reg[15:12] == 4'h0)
    else $error("Reserved enable bit set");

endmodule : latrap
`default_nettype wire

// File: hw/latrap_map.svh
// Register map, field positions and reset values of the audio I/O trap unit.
// Assumes 32-bit APB access, one register per aligned word.
`ifndef LATRAP_MAP_SVH
`define LATRAP_MAP_SVH
`define LAT_OFS_STATUS   8'h14
`define LAT_OFS_ENABLE   8'h18
`define LAT_OFS_IRQ_ST   8'h1c
`define LAT_OFS_IRQ_CLR  8'h20
`define LAT_OFS_IRQ_EN   8'h24
`define LAT_ENABLE_RST   16'h0000
`define LAT_ENABLE_MASK  16'h0fff
`define LAT_B_FASTWR     11
`define LAT_B_HIDMA      8
`define LAT_B_LODMA      7
`define LAT_B_HIMPU      6
`define LAT_B_LOMPU      5
`define LAT_B_FASTRD     4
`define LAT_B_SYNTH      3
`define LAT_B_SNDCARD    2
`define LAT_B_ST_FAST    13
`define LAT_B_ST_DMA     12
`define LAT_B_ST_MPU     11
`define LAT_B_ST_SND     10
`define LAT_IRQ_W        3
`endif

// File: hw/latrap_pkg.sv
// Types shared by the audio I/O trap unit.
// Assumes the map header defines offsets and field positions.
package latrap_pkg;
  // One legacy I/O cycle as issued by the host processor
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [9:0] addr;
    logic [7:0] data;
  } latrap_io_t;
  // The unit's own answer to a cycle that it claims
  typedef struct packed {
    logic       claim;
    logic [7:0] rdata;
  } latrap_rsp_t;
endpackage : latrap_pkg

// File: dv/latrap_host.sv
// Host model that issues legacy I/O cycles into the trap unit.
// Assumes the bench calls cycle() from one process, in step with mclk.
`timescale 1ns/1ps
`default_nettype none
module latrap_host
  import latrap_pkg::*;
(
  input  wire logic        mclk,
  output latrap_io_t       io_cyc,
  input  wire latrap_rsp_t io_rsp
);
  latrap_rsp_t last_rsp;
  // Bus idle from time zero
  initial io_cyc = '0;
  // One valid cycle; released lines carry inverted values so stale data never matches
  task automatic cycle(input logic [9:0] a, input logic wr, input logic [7:0] d);
    @(posedge mclk);
    io_cyc <= '{valid: 1'b1, write: wr, addr: a, data: d};
    @(negedge mclk);
    last_rsp = io_rsp;
    @(posedge mclk);
    io_cyc <= '{valid: 1'b0, write: ~wr, addr: ~a, data: ~d};
  endtask : cycle
endmodule : latrap_host
`default_nettype wire

// File: dv/latrap_bench.sv
// Self-checking bench of the audio I/O trap unit.
// Assumes the host model drives io cycles and this bench is the APB master.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module latrap_bench;
  import latrap_pkg::*;
  logic        mclk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic        sys_int, trap_pulse, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  latrap_io_t  io_cyc;
  latrap_rsp_t io_rsp;
  int          fails, checks_done, cyc;
  logic [32:0] q[$];
  logic [32:0] e;
  logic [1:0]  sel, fr;
  logic [9:0]  ta [6];
  int          eb [6] = '{8, 7, 6, 5, 3, 2};
  int          sb [6] = '{12, 12, 11, 11, 10, 10};
  logic [9:0]  miss [5] = '{10'h0e0, 10'h010, 10'h332, 10'h302, 10'h38c};

  latrap u_latrap (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .io_cyc(io_cyc), .io_rsp(io_rsp), .system_mgmt_interrupt(sys_int),
    .trap_pulse(trap_pulse), .irq(irq));
  latrap_host u_latrap_host (.mclk(mclk), .io_cyc(io_cyc), .io_rsp(io_rsp));

  // Free-running 40 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic tally_and_finish;
    if (fails == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  // Hang guard, sized well above the fewer than two hundred cycles the run needs
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      tally_and_finish();
    end
  end

  // Oldest note is compared when an access phase completes; mid-cycle sample is settled
  always @(negedge mclk)
    if (psel && penable && pready)
    begin
      e = q.pop_front();
      `CHK("pslverr", e[32], pslverr)
      if (!pwrite) `CHK("prdata", e[31:0], prdata)
    end

  // Setup then access, held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] x);
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    q.push_back(x);
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  // One io cycle, then the trap pulse is judged in the cycle after it
  task automatic trap(input logic [9:0] a, input logic wr, input logic [7:0] d,
                      input logic tp);
    u_latrap_host.cycle(a, wr, d);
    @(negedge mclk);
    `CHK("trap_pulse", tp, trap_pulse)
  endtask : trap

  initial
  begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; rst_b = 0;
    fails = 0; checks_done = 0; cyc = 0;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    void'($urandom(93));
    sel = 2'($urandom % 4);
    fr = 2'($urandom % 4);
    ta = '{10'h0c5, 10'h00a, 10'h331, 10'h300, 10'h389,
           10'h220 + {3'b0, sel, 5'b0} + 10'($urandom % 16)};
    apb(0, 8'h18, 0, 33'h0);
    apb(1, 8'h18, 32'hffff_ffff, 33'h0);
    apb(0, 8'h18, 0, {1'b0, 32'h0000_0fff});
    // Each range alone: flag, captured address, roll-up, then clear on read
    for (int i = 0; i < 6; i++)
    begin
      apb(1, 8'h18, (32'h1 << eb[i]) | sel, 33'h0);
      trap(ta[i], 1'b0, 8'h00, 1'b1);
      `CHK("system_mgmt_interrupt", 1'b1, sys_int)
      apb(0, 8'h14, 0, {1'b0, (32'h1 << sb[i]) | {22'h0, ta[i]}});
      apb(0, 8'h14, 0, {1'b0, 22'h0, ta[i]});
      @(negedge mclk);
      `CHK("system_mgmt_interrupt", 1'b0, sys_int)
    end
    // Near misses with every range on
    apb(1, 8'h18, 32'h1ec | sel, 33'h0);
    foreach (miss[i]) trap(miss[i], 1'b0, 8'h00, 1'b0);
    // Fast write: even port silent and claimed, odd port traps into bit 13
    apb(1, 8'h18, 32'h804, 33'h0);
    trap(10'h388, 1'b1, 8'ha5, 1'b0);
    `CHK("claim", 1'b1, u_latrap_host.last_rsp.claim)
    trap(10'h38b, 1'b1, 8'h3c, 1'b1);
    apb(0, 8'h14, 0, {1'b0, 8'ha5, 8'h3c, 3'b111, 3'b000, 10'h38b});
    trap(10'h22c, 1'b0, 8'h00, 1'b1);
    apb(0, 8'h14, 0, {1'b0, 8'ha5, 8'h3c, 3'b101, 3'b000, 10'h22c});
    apb(0, 8'h14, 0, {1'b0, 8'ha5, 8'h3c, 3'b100, 3'b000, 10'h22c});
    // Fast read returns the two-bit field
    apb(1, 8'h18, {21'h0, fr, 9'h010}, 33'h0);
    trap(10'h229, 1'b0, 8'h00, 1'b0);
    `CHK("fast read data", {6'h00, fr}, u_latrap_host.last_rsp.rdata)
    // Interrupt raised, masked, then cleared
    apb(1, 8'h20, 32'h7, 33'h0);
    apb(1, 8'h24, 32'h1, 33'h0);
    apb(1, 8'h18, 32'h100, 33'h0);
    trap(10'h0c0, 1'b1, 8'h5a, 1'b1);
    apb(0, 8'h1c, 0, {1'b0, 32'h1});
    `CHK("irq", 1'b1, irq)
    apb(1, 8'h24, 32'h0, 33'h0);
    apb(0, 8'h24, 0, 33'h0);
    `CHK("irq", 1'b0, irq)
    apb(1, 8'h24, 32'h1, 33'h0);
    apb(1, 8'h20, 32'h1, 33'h0);
    apb(0, 8'h1c, 0, 33'h0);
    `CHK("irq", 1'b0, irq)
    apb(0, 8'h30, 0, {1'b1, 32'h0});
    // Reset in mid-run clears enables and status
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    apb(0, 8'h18, 0, 33'h0);
    apb(0, 8'h14, 0, 33'h0);
    tally_and_finish();
  end
endmodule : latrap_bench
`default_nettype wire
